//--- src/fpsx_cfg.svh
// bit positions, reset values and field layouts of the status and exception unit
`ifndef FPSX_CFG_SVH
`define FPSX_CFG_SVH

// status word layout
`define FPSX_SW_EXC_LO 0
`define FPSX_SW_EXC_HI 5
`define FPSX_SW_SF 6
`define FPSX_SW_ES 7
`define FPSX_SW_C0 8
`define FPSX_SW_C1 9
`define FPSX_SW_C2 10
`define FPSX_SW_TOP_LO 11
`define FPSX_SW_TOP_HI 13
`define FPSX_SW_C3 14
`define FPSX_SW_B 15

// exception flag and mask positions, in order of precedence
`define FPSX_EXC_IE 0
`define FPSX_EXC_DE 1
`define FPSX_EXC_ZE 2
`define FPSX_EXC_OE 3
`define FPSX_EXC_UE 4
`define FPSX_EXC_PE 5
`define FPSX_EXC_NUM 6

// control word mask field
`define FPSX_CW_MASK_LO 0
`define FPSX_CW_MASK_HI 5

// reset values
`define FPSX_CW_RST 16'h003F
`define FPSX_SW_RST 16'h0000
`define FPSX_NO_EXC 3'h6

`endif

//--- src/fpsx_exc_detect.sv
// exception detection and condition code encoding for one finished instruction
`timescale 1ns/1ps
`default_nettype none
module fpsx_exc_detect
	import fpsx_pkg::*;
(
	// finished instruction
	input wire logic valid_i,
	input wire fpsx_opk_t op_i,
	input wire logic prem_incomplete_i,
	input wire logic [2:0] quotient_i,
	input wire fpsx_cmp_t cmp_i,
	input wire logic top_sign_i,
	input wire fpsx_cls_t top_class_i,
	input wire logic roundup_i,
	// conditions
	input wire logic snan_i,
	input wire logic unsupp_i,
	input wire logic indet_i,
	input wire logic stk_ovf_i,
	input wire logic stk_unf_i,
	input wire logic [1:0] opnd_min_exp_i,
	input wire logic [1:0] opnd_sig_nz_i,
	input wire logic divisor_zero_i,
	input wire logic dividend_fin_nz_i,
	input wire logic overflow_i,
	input wire logic underflow_i,
	input wire logic inexact_i,
	// results
	fpsx_exc_if.det det
);
	logic inv;
	logic zd;
	logic dn;
	logic stk;

	always_comb
	begin
		stk = stk_ovf_i | stk_unf_i;
		inv = snan_i | unsupp_i | indet_i | stk;
		zd = (op_i == OPK_DIV) & divisor_zero_i & dividend_fin_nz_i;
		dn = |(opnd_min_exp_i & opnd_sig_nz_i);
		det.flags = '0;
		det.stack = 1'h0;
		det.cc_we = 4'h0;
		det.cc_val = 4'h0;
		if (valid_i)
		begin
			det.flags = {inexact_i, underflow_i, overflow_i, zd, dn, inv};
			det.stack = stk;
			unique case (op_i)
				OPK_PREM:
				begin
					if (prem_incomplete_i)
					begin
						det.cc_we = 4'h4;
						det.cc_val = 4'h4;
					end
					else
					begin
						det.cc_we = 4'hF;
						det.cc_val = {quotient_i[1], 1'h0, quotient_i[0], quotient_i[2]};
					end
				end
				OPK_CMP:
				begin
					det.cc_we = 4'hF;
					unique case (cmp_i)
						CMP_GT: det.cc_val = 4'h0;
						CMP_LT: det.cc_val = 4'h1;
						CMP_EQ: det.cc_val = 4'h8;
						CMP_UNORD: det.cc_val = 4'hD;
					endcase
				end
				OPK_EXAM:
				begin
					det.cc_we = 4'hF;
					det.cc_val = {top_class_i[2], top_class_i[1], top_sign_i, top_class_i[0]};
				end
				OPK_ARITH, OPK_DIV:
				begin
					det.cc_we = 4'h2;
					det.cc_val = {2'h0, roundup_i & inexact_i, 1'h0};
				end
				default:
				begin
					det.cc_we = 4'h0;
				end
			endcase
			if (stk)
			begin
				det.cc_we[1] = 1'h1;
				det.cc_val[1] = stk_ovf_i;
			end
		end
	end

endmodule // fpsx_exc_detect
`default_nettype wire

//--- src/fpsx_exc_if.sv
// detector results passed to the status core
`timescale 1ns/1ps
`default_nettype none
interface fpsx_exc_if;
	logic [5:0] flags;
	logic stack;
	logic [3:0] cc_we;
	logic [3:0] cc_val;

	modport det (output flags, output stack, output cc_we, output cc_val);
	modport core (input flags, input stack, input cc_we, input cc_val);
endinterface
`default_nettype wire

//--- src/fpsx_pkg.sv
// types shared by the status and exception unit
package fpsx_pkg;

	typedef enum logic [2:0]
	{
		OPK_NONE = 3'h0,
		OPK_PREM = 3'h1,
		OPK_CMP = 3'h2,
		OPK_EXAM = 3'h3,
		OPK_ARITH = 3'h4,
		OPK_DIV = 3'h5
	} fpsx_opk_t;

	typedef enum logic [1:0]
	{
		CMP_GT = 2'h0,
		CMP_LT = 2'h1,
		CMP_EQ = 2'h2,
		CMP_UNORD = 2'h3
	} fpsx_cmp_t;

	// codes are the values placed in {C3,C2,C0}
	typedef enum logic [2:0]
	{
		CLS_UNSUPP = 3'h0,
		CLS_NAN = 3'h1,
		CLS_NORMAL = 3'h2,
		CLS_INF = 3'h3,
		CLS_ZERO = 3'h4,
		CLS_EMPTY = 3'h5,
		CLS_DENORM = 3'h6
	} fpsx_cls_t;

	// result taken by the datapath for the leading exception
	typedef enum logic [2:0]
	{
		ACT_NONE = 3'h0,
		ACT_QNAN_INDEF = 3'h1,
		ACT_CONTINUE = 3'h2,
		ACT_INFINITY = 3'h3,
		ACT_MAX_OR_INF = 3'h4,
		ACT_DENORM_OR_ZERO = 3'h5,
		ACT_TRAP = 3'h6
	} fpsx_act_t;

	typedef enum logic [1:0]
	{
		PF_REAL16 = 2'h0,
		PF_REAL32 = 2'h1,
		PF_PROT16 = 2'h2,
		PF_PROT32 = 2'h3
	} fpsx_pfmt_t;

	typedef struct packed
	{
		logic [15:0] cw;
		logic [5:0] exc;
		logic sf;
		logic es;
		logic [3:0] cc;
		logic [2:0] top;
		logic float_error_pin_n;
		logic exc16;
		logic ext_intr;
		logic [31:0] ip;
		logic [31:0] dp;
		logic [10:0] opc;
		logic dp_valid;
		fpsx_pfmt_t fmt;
		fpsx_act_t act;
		logic [2:0] first_exc;
	} fpsx_state_t;

	// index of the leading exception, 6 when none
	function automatic logic [2:0] fpsx_first_exc(input logic [5:0] f);
		logic [2:0] r;
		r = 3'h6;
		for (int i = 5; i >= 0; i--)
		begin
			if (f[i])
				r = 3'(i);
		end
		return r;
	endfunction

endpackage

//--- src/fpsx_status_unit.sv
// status word, exception masking, error pin and instruction pointers of the float unit
`timescale 1ns/1ps
`default_nettype none
`include "fpsx_cfg.svh"
// Notes on behaviour
// - incomplete partial remainder sets C2; other condition bits keep no meaning
// - complete remainder clears C2, quotient bits 2,1,0 go to C0,C3,C1
// - compare gives C3,C2,C0: greater 000, less 001, equal 100, unordered 111
// - examine puts top sign in C1 and operand class in C3,C2,C0
// - error summary bit 7 set exactly when an unmasked flag in bits 0-5 is set
// - error pin asserted whenever the error summary bit is set
// - bit 6 marks stack misuse; bit 9 then says overflow one, underflow zero
// - a detected exception sets its flag among status bits 0 to 5
// - each flag has its own mask; masked flags set but raise no summary
// - pending error traps next float or wait op; external interrupt if enabled
// - precedence: invalid, denormal, zero divide, overflow, underflow, inexact
// - invalid for signalling NaN, unsupported, indeterminate or stack misuse with bit 6
// - zero divide needs finite nonzero dividend; denormal is min exponent, nonzero significand
// - masked results: NaN/indefinite, infinity, max or infinity, denormal or zero, continue
// - on environment or state reload bits 7 and 15 are recomputed, not loaded
// - a reload leaving the summary set asserts the error pin at once
// - each decoded float op without a same-cycle environment load captures instruction address and opcode, and the operand address only when one is present
// - pointer format chosen by protected/real and 32/16 bit size; V86 is real
// - data pointer undefined after an op without memory operand
// - pointers move only on a decoded float op or an environment or state load
// - mask bits sit in control word bits 0 to 5 matching the flags
module fpsx_status_unit
	import fpsx_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic NRST_I,
	// finished instruction
	input wire logic RESULT_VALID_I,
	input wire fpsx_opk_t OP_KIND_I,
	input wire logic PREM_INCOMPLETE_I,
	input wire logic [2:0] QUOTIENT_I,
	input wire fpsx_cmp_t CMP_RESULT_I,
	input wire logic TOP_SIGN_I,
	input wire fpsx_cls_t TOP_CLASS_I,
	input wire logic ROUNDUP_I,
	// exception conditions
	input wire logic SNAN_I,
	input wire logic UNSUPPORTED_I,
	input wire logic INDETERMINATE_I,
	input wire logic STACK_OVF_I,
	input wire logic STACK_UNF_I,
	input wire logic [1:0] OPND_MIN_EXP_I,
	input wire logic [1:0] OPND_SIG_NZ_I,
	input wire logic DIVISOR_ZERO_I,
	input wire logic DIVIDEND_FIN_NZ_I,
	input wire logic OVERFLOW_I,
	input wire logic UNDERFLOW_I,
	input wire logic INEXACT_I,
	// control and status word access
	input wire logic CW_LOAD_I,
	input wire logic [15:0] CW_DATA_I,
	input wire logic SW_LOAD_I,
	input wire logic [15:0] SW_DATA_I,
	input wire logic CLEAR_EXC_I,
	output logic [15:0] CW_O,
	output logic [15:0] SW_O,
	// error reporting
	input wire logic FP_OR_WAIT_I,
	input wire logic NATIVE_ERROR_ENABLE_I,
	output logic FLOAT_ERROR_PIN_N_O,
	output logic EXC16_O,
	output logic EXT_INTR_O,
	output fpsx_act_t MASKED_ACTION_O,
	output logic [2:0] FIRST_EXC_O,
	// instruction decode
	input wire logic DECODE_VALID_I,
	input wire logic [31:0] INSTR_ADDR_I,
	input wire logic [31:0] OPND_ADDR_I,
	input wire logic OPND_PRESENT_I,
	input wire logic [10:0] OPCODE_I,
	input wire logic PROT_MODE_I,
	input wire logic V86_MODE_I,
	input wire logic OPSIZE32_I,
	// pointer environment transfer
	input wire logic PTR_LOAD_I,
	input wire logic [31:0] PTR_IP_I,
	input wire logic [31:0] PTR_DP_I,
	input wire logic [10:0] PTR_OPC_I,
	input wire fpsx_pfmt_t PTR_FMT_I,
	output logic [31:0] PTR_IP_O,
	output logic [31:0] PTR_DP_O,
	output logic [10:0] PTR_OPC_O,
	output fpsx_pfmt_t PTR_FMT_O,
	output logic PTR_DP_VALID_O
);
	fpsx_state_t s_r;
	fpsx_state_t s_nxt;
	fpsx_exc_if det_if ();
	logic [2:0] lead;
	logic [5:0] unmasked;

	fpsx_exc_detect u_detect (
		.valid_i(RESULT_VALID_I),
		.op_i(OP_KIND_I),
		.prem_incomplete_i(PREM_INCOMPLETE_I),
		.quotient_i(QUOTIENT_I),
		.cmp_i(CMP_RESULT_I),
		.top_sign_i(TOP_SIGN_I),
		.top_class_i(TOP_CLASS_I),
		.roundup_i(ROUNDUP_I),
		.snan_i(SNAN_I),
		.unsupp_i(UNSUPPORTED_I),
		.indet_i(INDETERMINATE_I),
		.stk_ovf_i(STACK_OVF_I),
		.stk_unf_i(STACK_UNF_I),
		.opnd_min_exp_i(OPND_MIN_EXP_I),
		.opnd_sig_nz_i(OPND_SIG_NZ_I),
		.divisor_zero_i(DIVISOR_ZERO_I),
		.dividend_fin_nz_i(DIVIDEND_FIN_NZ_I),
		.overflow_i(OVERFLOW_I),
		.underflow_i(UNDERFLOW_I),
		.inexact_i(INEXACT_I),
		.det(det_if.det)
	);

	// masked default result for the leading exception
	function automatic fpsx_act_t masked_action(input logic [2:0] idx);
		fpsx_act_t a;
		a = ACT_NONE;
		unique case (idx)
			3'h0: a = ACT_QNAN_INDEF;
			3'h1: a = ACT_CONTINUE;
			3'h2: a = ACT_INFINITY;
			3'h3: a = ACT_MAX_OR_INF;
			3'h4: a = ACT_DENORM_OR_ZERO;
			3'h5: a = ACT_CONTINUE;
			default: a = ACT_NONE;
		endcase
		return a;
	endfunction

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.exc16 = 1'h0;
		s_nxt.ext_intr = 1'h0;
		if (CW_LOAD_I)
			s_nxt.cw = CW_DATA_I;
		if (CLEAR_EXC_I)
		begin
			s_nxt.exc = 6'h00;
			s_nxt.sf = 1'h0;
		end
		// reload takes flags, codes and top; summary is recomputed below
		if (SW_LOAD_I)
		begin
			s_nxt.exc = SW_DATA_I[`FPSX_SW_EXC_HI:`FPSX_SW_EXC_LO];
			s_nxt.sf = SW_DATA_I[`FPSX_SW_SF];
			s_nxt.cc = {SW_DATA_I[`FPSX_SW_C3], SW_DATA_I[`FPSX_SW_C2],
				SW_DATA_I[`FPSX_SW_C1], SW_DATA_I[`FPSX_SW_C0]};
			s_nxt.top = SW_DATA_I[`FPSX_SW_TOP_HI:`FPSX_SW_TOP_LO];
		end
		// new events set after any clear, so they win
		s_nxt.exc = s_nxt.exc | det_if.flags;
		if (det_if.stack)
			s_nxt.sf = 1'h1;
		for (int i = 0; i < 4; i++)
		begin
			if (det_if.cc_we[i])
				s_nxt.cc[i] = det_if.cc_val[i];
		end
		unmasked = s_nxt.exc & ~s_nxt.cw[`FPSX_CW_MASK_HI:`FPSX_CW_MASK_LO];
		s_nxt.es = |unmasked;
		s_nxt.float_error_pin_n = ~s_nxt.es;
		if (FP_OR_WAIT_I && s_r.es)
		begin
			if (NATIVE_ERROR_ENABLE_I)
				s_nxt.ext_intr = 1'h1;
			else
				s_nxt.exc16 = 1'h1;
		end
		lead = fpsx_first_exc(det_if.flags);
		if (RESULT_VALID_I)
		begin
			s_nxt.first_exc = lead;
			if (lead == `FPSX_NO_EXC)
				s_nxt.act = ACT_NONE;
			else if (s_nxt.cw[lead])
				s_nxt.act = masked_action(lead);
			else
				s_nxt.act = ACT_TRAP;
		end
		if (DECODE_VALID_I)
		begin
			s_nxt.ip = INSTR_ADDR_I;
			s_nxt.opc = OPCODE_I;
			s_nxt.dp_valid = OPND_PRESENT_I;
			if (OPND_PRESENT_I)
				s_nxt.dp = OPND_ADDR_I;
			s_nxt.fmt = fpsx_pfmt_t'({PROT_MODE_I & ~V86_MODE_I, OPSIZE32_I});
		end
		// environment load overrides a decode in the same cycle
		if (PTR_LOAD_I)
		begin
			s_nxt.ip = PTR_IP_I;
			s_nxt.dp = PTR_DP_I;
			s_nxt.opc = PTR_OPC_I;
			s_nxt.fmt = PTR_FMT_I;
			s_nxt.dp_valid = 1'h1;
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			s_r <= '0;
			s_r.cw <= `FPSX_CW_RST;
			s_r.exc <= 6'(`FPSX_SW_RST);
			s_r.float_error_pin_n <= 1'h1;
			s_r.first_exc <= `FPSX_NO_EXC;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign CW_O = s_r.cw;
	assign SW_O = {s_r.es, s_r.cc[3], s_r.top, s_r.cc[2], s_r.cc[1], s_r.cc[0],
		s_r.es, s_r.sf, s_r.exc};
	assign FLOAT_ERROR_PIN_N_O = s_r.float_error_pin_n;
	assign EXC16_O = s_r.exc16;
	assign EXT_INTR_O = s_r.ext_intr;
	assign MASKED_ACTION_O = s_r.act;
	assign FIRST_EXC_O = s_r.first_exc;
	assign PTR_IP_O = s_r.ip;
	assign PTR_DP_O = s_r.dp;
	assign PTR_OPC_O = s_r.opc;
	assign PTR_FMT_O = s_r.fmt;
	assign PTR_DP_VALID_O = s_r.dp_valid;

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!NRST_I);

	logic plain_op;
	assign plain_op = RESULT_VALID_I && !SW_LOAD_I && !STACK_OVF_I && !STACK_UNF_I;

	chk_summary_bit: assert property (SW_O[`FPSX_SW_ES] == |(SW_O[5:0] & ~CW_O[5:0])
		&& SW_O[`FPSX_SW_B] == SW_O[`FPSX_SW_ES])
		else $error("summary bit disagrees with flags and masks");
	chk_error_pin: assert property (FLOAT_ERROR_PIN_N_O == !SW_O[`FPSX_SW_ES])
		else $error("error pin does not follow summary bit");
	chk_flag_sticky: assert property (RESULT_VALID_I && (det_if.flags != 6'h00)
		|=> ((SW_O[5:0] & $past(det_if.flags)) == $past(det_if.flags)))
		else $error("detected exception flag not set");
	chk_flag_hold: assert property (!CLEAR_EXC_I && !SW_LOAD_I && SW_O[0]
		|=> SW_O[0])
		else $error("invalid flag dropped without clear");
	// the pulse may only last longer when another float or wait op found the error pending
	chk_trap_raise: assert property (FP_OR_WAIT_I && SW_O[`FPSX_SW_ES]
		&& !NATIVE_ERROR_ENABLE_I |=> EXC16_O && !EXT_INTR_O ##1 (!EXC16_O
		|| $past(FP_OR_WAIT_I && SW_O[`FPSX_SW_ES] && !NATIVE_ERROR_ENABLE_I)))
		else $error("pending error did not raise vector 16");
	chk_intr_raise: assert property (FP_OR_WAIT_I && SW_O[`FPSX_SW_ES]
		&& NATIVE_ERROR_ENABLE_I |=> EXT_INTR_O && !EXC16_O)
		else $error("pending error did not signal external interrupt");
	chk_no_trap: assert property (!(FP_OR_WAIT_I && SW_O[`FPSX_SW_ES])
		|=> !EXC16_O && !EXT_INTR_O)
		else $error("error raised without pending error");
	chk_reload_summary: assert property (SW_LOAD_I && !RESULT_VALID_I && !CW_LOAD_I
		|=> SW_O[`FPSX_SW_ES] == |($past(SW_DATA_I[5:0]) & ~CW_O[5:0])
		&& FLOAT_ERROR_PIN_N_O == !SW_O[`FPSX_SW_ES])
		else $error("reload summary not recomputed");
	chk_prem_partial: assert property (plain_op && OP_KIND_I == OPK_PREM
		&& PREM_INCOMPLETE_I |=> SW_O[`FPSX_SW_C2])
		else $error("incomplete remainder left C2 clear");
	chk_prem_quot: assert property (plain_op && OP_KIND_I == OPK_PREM && !PREM_INCOMPLETE_I
		|=> !SW_O[`FPSX_SW_C2] && {SW_O[`FPSX_SW_C0], SW_O[`FPSX_SW_C3], SW_O[`FPSX_SW_C1]}
		== $past(QUOTIENT_I))
		else $error("quotient bits misplaced");
	chk_cmp_codes: assert property (plain_op && OP_KIND_I == OPK_CMP && CMP_RESULT_I == CMP_LT
		|=> {SW_O[`FPSX_SW_C3], SW_O[`FPSX_SW_C2], SW_O[`FPSX_SW_C0]} == 3'h1)
		else $error("compare less code wrong");
	chk_cmp_equal: assert property (plain_op && OP_KIND_I == OPK_CMP && CMP_RESULT_I == CMP_EQ
		|=> {SW_O[`FPSX_SW_C3], SW_O[`FPSX_SW_C2], SW_O[`FPSX_SW_C0]} == 3'h4)
		else $error("compare equal code wrong");
	chk_cmp_unord: assert property (plain_op && OP_KIND_I == OPK_CMP && CMP_RESULT_I == CMP_UNORD
		|=> {SW_O[`FPSX_SW_C3], SW_O[`FPSX_SW_C2], SW_O[`FPSX_SW_C0]} == 3'h7)
		else $error("compare unordered code wrong");
	chk_exam_codes: assert property (plain_op && OP_KIND_I == OPK_EXAM
		|=> {SW_O[`FPSX_SW_C3], SW_O[`FPSX_SW_C2], SW_O[`FPSX_SW_C0]} == $past(TOP_CLASS_I)
		&& SW_O[`FPSX_SW_C1] == $past(TOP_SIGN_I))
		else $error("examine class code wrong");
	chk_stack_fault: assert property (RESULT_VALID_I && STACK_OVF_I
		|=> SW_O[`FPSX_SW_SF] && SW_O[`FPSX_EXC_IE] && SW_O[`FPSX_SW_C1])
		else $error("stack overflow not reported");
	// underflow alone must leave C1 low while the stack fault stands
	chk_stack_under: assert property (RESULT_VALID_I && STACK_UNF_I && !STACK_OVF_I
		|=> SW_O[`FPSX_SW_SF] && SW_O[`FPSX_EXC_IE] && !SW_O[`FPSX_SW_C1])
		else $error("stack underflow not reported");
	// invalid leads every other exception, so a masked one always picks the NaN result
	chk_masked_inv: assert property (RESULT_VALID_I && SNAN_I && CW_O[`FPSX_EXC_IE] && !CW_LOAD_I
		|=> MASKED_ACTION_O == ACT_QNAN_INDEF && FIRST_EXC_O == 3'h0)
		else $error("masked invalid result wrong");
	chk_lead_exc: assert property (RESULT_VALID_I
		|=> FIRST_EXC_O == fpsx_first_exc($past(det_if.flags)))
		else $error("leading exception wrong");
	chk_zero_div: assert property (RESULT_VALID_I && OP_KIND_I == OPK_DIV && DIVISOR_ZERO_I
		&& DIVIDEND_FIN_NZ_I && CW_O[`FPSX_EXC_ZE] && !CW_LOAD_I && !SNAN_I
		&& !UNSUPPORTED_I && !INDETERMINATE_I && !STACK_OVF_I && !STACK_UNF_I
		&& !(|(OPND_MIN_EXP_I & OPND_SIG_NZ_I))
		|=> SW_O[`FPSX_EXC_ZE] && MASKED_ACTION_O == ACT_INFINITY)
		else $error("masked zero divide mishandled");
	chk_ptr_capture: assert property (DECODE_VALID_I && !PTR_LOAD_I
		|=> PTR_IP_O == $past(INSTR_ADDR_I) && PTR_OPC_O == $past(OPCODE_I)
		&& PTR_DP_VALID_O == $past(OPND_PRESENT_I))
		else $error("pointer capture wrong");
	chk_ptr_format: assert property (DECODE_VALID_I && !PTR_LOAD_I && V86_MODE_I
		|=> PTR_FMT_O == PF_REAL16 || PTR_FMT_O == PF_REAL32)
		else $error("virtual mode used protected pointer format");

	cov_trap: cover property (FP_OR_WAIT_I && SW_O[`FPSX_SW_ES] ##1 EXC16_O);
	cov_intr: cover property (FP_OR_WAIT_I && SW_O[`FPSX_SW_ES] ##1 EXT_INTR_O);
	cov_reload_err: cover property (SW_LOAD_I ##1 !FLOAT_ERROR_PIN_N_O);
	cov_set_clear: cover property (CLEAR_EXC_I && RESULT_VALID_I && det_if.flags != 6'h00);
	cov_stack: cover property (RESULT_VALID_I && (STACK_OVF_I || STACK_UNF_I) ##1 SW_O[`FPSX_SW_SF]);

endmodule // fpsx_status_unit
`default_nettype wire

//--- tb/fpsx_env_model.sv
// partner model: environment store and reload of the float pointers
`timescale 1ns/1ps
`default_nettype none
module fpsx_env_model
(
	// clock
	input wire logic clk_i,
	// requests from the integer core
	input wire logic store_i,
	input wire logic restore_i,
	// pointers read from the unit
	input wire logic [31:0] ip_i,
	input wire logic [31:0] dp_i,
	input wire logic [10:0] opc_i,
	input wire logic [1:0] fmt_i,
	// pointers loaded into the unit
	output logic load_o,
	output logic [31:0] ip_o,
	output logic [31:0] dp_o,
	output logic [10:0] opc_o,
	output logic [1:0] fmt_o
);
	logic [76:0] img_r;

	// the memory image changes only through a store or save
	always_ff @(posedge clk_i)
		if (store_i)
			img_r <= {ip_i, dp_i, opc_i, fmt_i};

	// outside a reload the bus holds no image, so it shows the inverse
	assign load_o = restore_i;
	assign {ip_o, dp_o, opc_o, fmt_o} = restore_i ? img_r : ~img_r;
endmodule // fpsx_env_model
`default_nettype wire

//--- tb/test_fpsx_status_unit.sv
// self-checking bench for the float status and exception unit
`timescale 1ns/1ps
`default_nettype none
module test_fpsx_status_unit
	import fpsx_pkg::*;
;
	localparam int WATCH_CYC = 8000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rv, pinc, tsign, rup, snan, unsup, indet, sovf, sunf, dz, dfnz, ovf, unf, inx;
	logic cwld, swld, clr, fpw, ne, dec, opres, prot, v86, os32, store, restore;
	logic [2:0] quo;
	logic [1:0] mexp, signz;
	logic [15:0] cwd, swd;
	logic [31:0] iaddr, oaddr;
	logic [10:0] opc;
	fpsx_opk_t opk;
	fpsx_cmp_t cmpr;
	fpsx_cls_t cls;
	logic [15:0] cw_q, sw_q;
	logic float_error_pin_n, exc16, extint, pdv, ptl;
	fpsx_act_t act_q;
	logic [2:0] first_q;
	logic [31:0] pip, pdp, lip, ldp;
	logic [10:0] popc, lopc;
	fpsx_pfmt_t pfmt;
	logic [1:0] lfmt;
	integer seed = 32'h1DE6;
	int errors = 0;
	int n_compared = 0;
	logic [15:0] e_cw;
	logic [5:0] e_flags;
	logic [3:0] e_cc, e_care;
	logic [2:0] e_top, e_first;
	logic e_sf, e_trap, e_ext, e_dv, have_img;
	fpsx_act_t e_act;
	logic [31:0] e_ip, e_dp, s_ip, s_dp;
	logic [10:0] e_opc, s_opc;
	fpsx_pfmt_t e_fmt, s_fmt;
	logic [2:0] cmp_code [0:3] = '{3'h0, 3'h1, 3'h4, 3'h7};

	fpsx_status_unit DUT
	(
		.CLK_I(clk), .NRST_I(rst_n), .RESULT_VALID_I(rv), .OP_KIND_I(opk),
		.PREM_INCOMPLETE_I(pinc), .QUOTIENT_I(quo), .CMP_RESULT_I(cmpr), .TOP_SIGN_I(tsign),
		.TOP_CLASS_I(cls), .ROUNDUP_I(rup), .SNAN_I(snan), .UNSUPPORTED_I(unsup),
		.INDETERMINATE_I(indet), .STACK_OVF_I(sovf), .STACK_UNF_I(sunf),
		.OPND_MIN_EXP_I(mexp), .OPND_SIG_NZ_I(signz), .DIVISOR_ZERO_I(dz),
		.DIVIDEND_FIN_NZ_I(dfnz), .OVERFLOW_I(ovf), .UNDERFLOW_I(unf), .INEXACT_I(inx),
		.CW_LOAD_I(cwld), .CW_DATA_I(cwd), .SW_LOAD_I(swld), .SW_DATA_I(swd),
		.CLEAR_EXC_I(clr), .CW_O(cw_q), .SW_O(sw_q), .FP_OR_WAIT_I(fpw),
		.NATIVE_ERROR_ENABLE_I(ne), .FLOAT_ERROR_PIN_N_O(float_error_pin_n), .EXC16_O(exc16),
		.EXT_INTR_O(extint), .MASKED_ACTION_O(act_q), .FIRST_EXC_O(first_q),
		.DECODE_VALID_I(dec), .INSTR_ADDR_I(iaddr), .OPND_ADDR_I(oaddr),
		.OPND_PRESENT_I(opres), .OPCODE_I(opc), .PROT_MODE_I(prot), .V86_MODE_I(v86),
		.OPSIZE32_I(os32), .PTR_LOAD_I(ptl), .PTR_IP_I(lip), .PTR_DP_I(ldp),
		.PTR_OPC_I(lopc), .PTR_FMT_I(fpsx_pfmt_t'(lfmt)), .PTR_IP_O(pip), .PTR_DP_O(pdp),
		.PTR_OPC_O(popc), .PTR_FMT_O(pfmt), .PTR_DP_VALID_O(pdv)
	);

	fpsx_env_model partner
	(
		.clk_i(clk), .store_i(store), .restore_i(restore), .ip_i(pip), .dp_i(pdp),
		.opc_i(popc), .fmt_i(pfmt), .load_o(ptl), .ip_o(lip), .dp_o(ldp), .opc_o(lopc),
		.fmt_o(lfmt)
	);

	always #5 clk = ~clk;

	function automatic logic es_of(input logic [5:0] f, input logic [15:0] c);
		return |(f & ~c[5:0]);
	endfunction

	function automatic logic [2:0] lead(input logic [5:0] d);
		for (int i = 0; i < 6; i++)
			if (d[i])
				return 3'(i);
		return 3'h6;
	endfunction

	function automatic fpsx_act_t act_of(input logic [2:0] f, input logic [15:0] c);
		if (f == 3'h6)
			return ACT_NONE;
		if (!c[f])
			return ACT_TRAP;
		case (f)
			3'h0: return ACT_QNAN_INDEF;
			3'h2: return ACT_INFINITY;
			3'h3: return ACT_MAX_OR_INF;
			3'h4: return ACT_DENORM_OR_ZERO;
			default: return ACT_CONTINUE;
		endcase
	endfunction

	task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s: expected %0h, seen %0h", nm, e, g);
		end
	endtask

	task automatic stop_test;
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic idle;
		{rv, pinc, quo, tsign, rup, snan, unsup, indet, sovf, sunf, mexp, signz} <= '0;
		{dz, dfnz, ovf, unf, inx, cwld, cwd, swld, swd, clr, fpw, ne, dec} <= '0;
		{iaddr, oaddr, opres, opc, prot, v86, os32, store, restore} <= '0;
		opk <= OPK_NONE;
		cmpr <= CMP_GT;
		cls <= CLS_UNSUPP;
	endtask

	task automatic init_exp;
		{e_flags, e_sf, e_cc, e_top, e_trap, e_ext, e_ip, e_dp, e_opc, e_dv} = '0;
		e_cw = 16'h003F;
		e_care = 4'hF;
		e_first = 3'h6;
		e_act = ACT_NONE;
		e_fmt = PF_REAL16;
	endtask

	// k below 6 raises only exception k
	task automatic drive(input int k);
		int t;
		t = (k < 6) ? 31 : ($random(seed) & 31);
		rv <= t > 7;
		clr <= t == 5;
		swld <= t == 6;
		cwld <= t == 7;
		store <= t == 3 && e_dv;
		restore <= t == 4 && have_img;
		sovf <= t == 8;
		sunf <= t == 9;
		opk <= fpsx_opk_t'(3'($unsigned($random(seed)) % 6));
		cls <= fpsx_cls_t'(3'($unsigned($random(seed)) % 7));
		cmpr <= fpsx_cmp_t'(2'($random(seed)));
		{pinc, quo, tsign, rup, mexp, signz, ne, dec, opres, prot, v86, os32, fpw} <= 17'($random(seed));
		{snan, unsup, indet, ovf, unf, inx, dz, dfnz} <= 8'($random(seed) & $random(seed) & $random(seed));
		{cwd, swd} <= $random(seed);
		{iaddr, oaddr} <= {$random(seed), $random(seed)};
		opc <= 11'($random(seed));
		if (k < 6)
		begin
			opk <= OPK_DIV;
			{snan, unsup, indet, ovf, unf, inx, dz, dfnz} <= {k == 0, 2'h0, k == 3, k == 4, k == 5, k == 2, k == 2};
			mexp <= {1'b0, k == 1};
			signz <= 2'h3;
		end
	endtask

	task automatic predict;
		logic [5:0] d;
		logic es;
		es = es_of(e_flags, e_cw);
		e_trap = fpw & es & !ne;
		e_ext = fpw & es & ne;
		if (clr)
			{e_flags, e_sf} = '0;
		if (swld)
		begin
			{e_cc[3], e_top, e_cc[2:0], e_sf, e_flags} = {swd[14:8], swd[6:0]};
			e_care = 4'hF;
		end
		if (cwld)
			e_cw = cwd;
		if (rv)
		begin
			d = {inx, unf, ovf, opk == OPK_DIV && dz && dfnz, |(mexp & signz), snan | unsup | indet | sovf | sunf};
			e_flags = e_flags | d;
			e_first = lead(d);
			e_act = act_of(e_first, e_cw);
			if (opk == OPK_PREM && pinc)
			begin
				e_cc[2] = 1'b1;
				e_care = 4'h4;
			end
			else if (opk == OPK_PREM)
				{e_care, e_cc} = {4'hF, quo[1], 1'b0, quo[0], quo[2]};
			else if (opk == OPK_CMP)
				{e_care, e_cc} = {4'hF, cmp_code[cmpr][2:1], 1'b0, cmp_code[cmpr][0]};
			else if (opk == OPK_EXAM)
				{e_care, e_cc} = {4'hF, cls[2:1], tsign, cls[0]};
			else if (opk != OPK_NONE)
				{e_care[1], e_cc[1]} = {1'b1, rup & inx};
			if (sovf | sunf)
				{e_sf, e_care[1], e_cc[1]} = {2'h3, sovf};
		end
		if (store)
			{s_ip, s_dp, s_opc, s_fmt, have_img} = {e_ip, e_dp, e_opc, e_fmt, 1'b1};
		if (ptl)
			{e_ip, e_dp, e_opc, e_fmt, e_dv} = {s_ip, s_dp, s_opc, s_fmt, 1'b1};
		else if (dec)
		begin
			{e_ip, e_opc, e_dv} = {iaddr, opc, opres};
			e_fmt = fpsx_pfmt_t'({prot & !v86, os32});
			if (opres)
				e_dp = oaddr;
		end
	endtask

	task automatic check;
		logic [15:0] m;
		m = ~{1'b0, ~e_care[3], 3'h0, ~e_care[2:0], 8'h00};
		cmp("control word", e_cw, cw_q);
		cmp("status word", {es_of(e_flags, e_cw), e_cc[3], e_top, e_cc[2:0], es_of(e_flags, e_cw), e_sf, e_flags} & m, sw_q & m);
		cmp("error pin", !es_of(e_flags, e_cw), float_error_pin_n);
		cmp("vector 16", e_trap, exc16);
		cmp("external interrupt", e_ext, extint);
		cmp("leading exception", e_first, first_q);
		cmp("masked action", e_act, act_q);
		cmp("pointers", {e_dv, e_fmt, e_opc, e_ip}, {pdv, pfmt, popc, pip});
		if (e_dv)
			cmp("data pointer", e_dp, pdp);
	endtask

	task automatic step(input int k);
		@(posedge clk);
		drive(k);
		@(negedge clk);
		check();
		predict();
	endtask

	task automatic do_reset;
		@(posedge clk);
		idle();
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		init_exp();
		@(negedge clk);
		check();
		@(posedge clk);
		rst_n <= 1'b1;
	endtask

	initial
	begin
		have_img = 1'b0;
		idle();
		do_reset();
		repeat (1500) step(6);
		for (int k = 0; k < 6; k++)
			step(k);
		do_reset();
		for (int k = 0; k < 6; k++)
			step(k);
		repeat (1500) step(6);
		stop_test();
	end

	initial
	begin
		#(WATCH_CYC * 10);
		errors++;
		stop_test();
	end
endmodule // test_fpsx_status_unit
`default_nettype wire
